// ---- rtl/fnel_pkg.sv ----
// fnel_pkg: register map, field positions, reset values and helpers of the
// first/next error logger.
// assumes: 12-bit byte address, 32-bit data, one link port per logger instance.
package fnel_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] OFS_GLOBAL_FIRST   = 12'h040;
   localparam logic [11:0] OFS_GLOBAL_NEXT    = 12'h044;
   localparam logic [11:0] OFS_PORT_FIRST_FAT = 12'h154;
   localparam logic [11:0] OFS_PORT_FIRST_NFC = 12'h158;
   localparam logic [11:0] OFS_PORT_NEXT_FAT  = 12'h15C;
   localparam logic [11:0] OFS_PORT_NEXT_NFC  = 12'h160;
   localparam logic [11:0] OFS_UNIT_FIRST     = 12'h168;
   localparam logic [11:0] OFS_UNIT_NEXT      = 12'h16C;
   localparam logic [11:0] OFS_STOP_SCREAM    = 12'h170;

   // port log widths and fields
   localparam int PORT_FAT_W = 13;
   localparam int PORT_NFC_W = 18;
   localparam int NFC_SLD_BIT = 17;                       // surprise link down
   localparam logic [17:0] NFC_UNCORR_MASK = 18'h207FF;   // bits 17 and 10:0
   localparam logic [17:0] NFC_RW_MASK     = 18'h20000;   // read-write sticky bits

   // global register fields
   localparam int GL_HALF_W      = 16;
   localparam int GL_MEM_FAT_BIT = 24;
   localparam int GL_MEM_NF_BIT  = 8;
   localparam logic [31:0] GFIRST_VALID = 32'hFFFD_FFFD;  // 17 and 1 reserved
   localparam logic [31:0] GNEXT_VALID  = 32'hF1FD_F1FD;  // 27:25, 17, 11:9, 1 reserved

   localparam logic [31:0] STICKY_RST = 32'h0000_0000;
   localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

   // sticky status update: the set term is applied last so a new error wins
   function automatic logic [31:0] w1c_upd(input logic [31:0] cur,
                                           input logic [31:0] set,
                                           input logic [31:0] clr);
      return (cur & ~clr) | set;
   endfunction : w1c_upd

   // ecc failures decode only to a branch: log on the branch's lower channel
   function automatic logic [3:0] ecc_to_chan(input logic [1:0] branch);
      return {1'b0, branch[1], 1'b0, branch[0]};
   endfunction : ecc_to_chan

endpackage : fnel_pkg

// ---- rtl/fnel_log_if.sv ----
// fnel_log_if: carries one first/next log pair between the top and its logger.
// assumes: all signals belong to the logger's clock domain.
`timescale 1ns/1ps
interface fnel_log_if #(parameter int W = 8);
   logic [W-1:0] evt;       // unmasked error events this cycle
   logic         wr_first;  // software write to the first register
   logic         wr_next;   // software write to the next register
   logic [W-1:0] wdata;
   logic [W-1:0] first;
   logic [W-1:0] next;
   modport log (input evt, wr_first, wr_next, wdata, output first, next);
   modport ctl (output evt, wr_first, wr_next, wdata, input first, next);
endinterface : fnel_log_if

// ---- rtl/fnel_pair_log.sv ----
// fnel_pair_log: per-bit first error register and its next error register.
// assumes: power_good low clears the logs; rst_in does not touch them.
`timescale 1ns/1ps
module fnel_pair_log
   import fnel_pkg::*;
#(
   parameter int          W       = 8,
   parameter logic [31:0] RW_MASK = 32'h0000_0000
) (
   input  wire logic clk_in,
   input  wire logic power_good_in,
   input  wire logic ce_in,
   fnel_log_if.log   lg
);
   initial begin
      if (W < 1 || W > DATA_W) $error("fnel_pair_log: W out of range");
   end

   logic [W-1:0] first_reg;
   logic [W-1:0] next_reg;
   logic [W-1:0] first_clr;
   logic [W-1:0] rw_keep;

   assign first_clr = lg.wr_first ? lg.wdata : '0;
   assign rw_keep   = lg.wr_next ? lg.wdata : next_reg;

   // first log: an event sets its bit only if it is clear; clearing a set bit beats an event in the same cycle
   always_ff @(posedge clk_in or negedge power_good_in) begin
      if (!power_good_in) begin
         first_reg <= STICKY_RST[W-1:0];
      end else if (ce_in) begin
         first_reg <= W'(w1c_upd(32'(first_reg), 32'(lg.evt & ~first_reg),
                                 32'(first_clr)));
      end
   end

   // next log: only errors whose first bit was already set land here
   always_ff @(posedge clk_in or negedge power_good_in) begin
      if (!power_good_in) begin
         next_reg <= STICKY_RST[W-1:0];
      end else if (ce_in) begin
         for (int i = 0; i < W; i++) begin
            if (RW_MASK[i]) begin
               next_reg[i] <= rw_keep[i] | (lg.evt[i] & first_reg[i]);
            end else begin
               next_reg[i] <= (next_reg[i] & ~(lg.wr_next & lg.wdata[i]))
                              | (lg.evt[i] & first_reg[i]);
            end
         end
      end
   end

   assign lg.first = first_reg;
   assign lg.next  = next_reg;

   a_next_needs_first: assert property (@(posedge clk_in) disable iff (!power_good_in)
      ce_in |=> ((next_reg & ~$past(next_reg) & ~$past(first_reg) & ~W'(RW_MASK)) == '0))
      else $error("next bit set without its first bit");
   a_first_catches: assert property (@(posedge clk_in) disable iff (!power_good_in)
      ce_in && (lg.evt != '0) |=> ((first_reg | next_reg) & $past(lg.evt)) == $past(lg.evt))
      else $error("unmasked error lost by the logs");

endmodule : fnel_pair_log

// ---- rtl/fnel_top.sv ----
// fnel_top: first/next error logger for one link port plus the global pair.
// assumes: error inputs are one-cycle pulses synchronous to ref_clk_in;
// power_good_in low is the only reset that clears the sticky logs.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

// Operation
// - port next non-fatal/correctable bit records only if its first bit is set
// - next non-fatal bit 17, surprise link down, is sticky read-write
// - correctable next bits: message 16, replay timeout 15 ... receiver 11
// - uncorrectable next bits 10 down to 0 in the fixed order
// - next fatal bits: overflow 9 down to link protocol 0
// - unit first bit 0 set by first voltage-controller error if clear
// - unit errors forwarded to central logic, classed by port cluster
// - unit next bit 0 set by later errors once first bit set
// - stop-and-scream flag set on first poisoning error while clear
// - global first catches first fatal and non-fatal, later go to next
// - global logs survive reset while power good stays high
// - only global first state gates detail log updates
// - global first fatal bits 31..16 in fixed source order, 17 reserved
// - global first non-fatal bits 15..0 same order, 1 reserved
// - ecc failure logged on lower channel of its branch
// - any memory channel fatal sets global next bit 24, 27:25 reserved
// - global next fatal 31:28 and 23:18 as first, 17 reserved
// - masked errors are neither reported nor logged
// - port first bit written only when not already set
module fnel_top
   import fnel_pkg::*;
#(
   parameter int PORT_NUM = 2
) (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  ce_in,
   input  wire logic                  power_good_in,
   input  wire logic [ADDR_W-1:0]     addr_in,
   input  wire logic [DATA_W-1:0]     wdata_in,
   input  wire logic                  wr_in,
   input  wire logic                  rd_in,
   output logic      [DATA_W-1:0]     rdata_out,
   input  wire logic [PORT_FAT_W-1:0] port_fat_evt_in,
   input  wire logic [PORT_FAT_W-1:0] port_fat_mask_in,
   input  wire logic [PORT_NFC_W-1:0] port_nfc_evt_in,
   input  wire logic [PORT_NFC_W-1:0] port_nfc_mask_in,
   input  wire logic                  vpp_evt_in,
   input  wire logic                  vpp_mask_in,
   input  wire logic                  stop_scream_flag_evt_in,
   input  wire logic [GL_HALF_W-1:0]  gl_fat_evt_in,
   input  wire logic [GL_HALF_W-1:0]  gl_nf_evt_in,
   input  wire logic [1:0]            mem_ecc_fat_in,
   input  wire logic [1:0]            mem_ecc_nf_in,
   output logic                       fat_log_en_out,
   output logic                       nf_log_en_out,
   output logic                       unit_cl23_out,
   output logic                       unit_cl47_out
);
   initial begin
      if (PORT_NUM < 2 || PORT_NUM > 7) $error("fnel_top: PORT_NUM must be 2..7");
   end

   // masked errors are dropped before anything sees them
   logic [PORT_FAT_W-1:0] fat_unm;
   logic [PORT_NFC_W-1:0] nfc_unm;
   logic                  vpp_unm;
   assign fat_unm = port_fat_evt_in & ~port_fat_mask_in;
   assign nfc_unm = port_nfc_evt_in & ~port_nfc_mask_in;
   assign vpp_unm = vpp_evt_in & ~vpp_mask_in;

   // write strobes per register
   logic wr_gfirst;
   logic wr_gnext;
   logic wr_stop_scream_flag;
   assign wr_gfirst = wr_in && (addr_in == OFS_GLOBAL_FIRST);
   assign wr_gnext  = wr_in && (addr_in == OFS_GLOBAL_NEXT);
   assign wr_stop_scream_flag  = wr_in && (addr_in == OFS_STOP_SCREAM);

   // port fatal log: bit order is the input order, 9..0 per the fatal list
   fnel_log_if #(.W(PORT_FAT_W)) fat_if ();
   assign fat_if.evt      = fat_unm;
   assign fat_if.wr_first = wr_in && (addr_in == OFS_PORT_FIRST_FAT);
   assign fat_if.wr_next  = wr_in && (addr_in == OFS_PORT_NEXT_FAT);
   assign fat_if.wdata    = wdata_in[PORT_FAT_W-1:0];

   fnel_pair_log #(.W(PORT_FAT_W), .RW_MASK(32'h0000_0000)) u_fat_log (
      .clk_in        (ref_clk_in),
      .power_good_in (power_good_in),
      .ce_in         (ce_in),
      .lg            (fat_if.log)
   );

   // non-fatal/correctable log: correctable 16..11, uncorrectable 10..0, 17
   fnel_log_if #(.W(PORT_NFC_W)) nfc_if ();
   assign nfc_if.evt      = nfc_unm;
   assign nfc_if.wr_first = wr_in && (addr_in == OFS_PORT_FIRST_NFC);
   assign nfc_if.wr_next  = wr_in && (addr_in == OFS_PORT_NEXT_NFC);
   assign nfc_if.wdata    = wdata_in[PORT_NFC_W-1:0];

   fnel_pair_log #(.W(PORT_NFC_W), .RW_MASK(32'(NFC_RW_MASK))) u_nfc_log (
      .clk_in        (ref_clk_in),
      .power_good_in (power_good_in),
      .ce_in         (ce_in),
      .lg            (nfc_if.log)
   );

   // unit (voltage-controller) log: one bit each
   fnel_log_if #(.W(1)) unit_if ();
   assign unit_if.evt      = vpp_unm;
   assign unit_if.wr_first = wr_in && (addr_in == OFS_UNIT_FIRST);
   assign unit_if.wr_next  = wr_in && (addr_in == OFS_UNIT_NEXT);
   assign unit_if.wdata    = wdata_in[0];

   fnel_pair_log #(.W(1), .RW_MASK(32'h0000_0000)) u_unit_log (
      .clk_in        (ref_clk_in),
      .power_good_in (power_good_in),
      .ce_in         (ce_in),
      .lg            (unit_if.log)
   );

   // stop-and-scream flag: first poisoning error only, no next copy
   logic stop_scream_flag_reg;
   always_ff @(posedge ref_clk_in or negedge power_good_in) begin
      if (!power_good_in) begin
         stop_scream_flag_reg <= STICKY_RST[0];
      end else if (ce_in) begin
         // re-setting a set flag changes nothing, so only the first counts; set beats clear
         stop_scream_flag_reg <= (stop_scream_flag_reg & ~(wr_stop_scream_flag & wdata_in[0]))
                      | stop_scream_flag_evt_in;
      end
   end

   // global event vector; this port reports its own uncorrectable errors
   logic [GL_HALF_W-1:0] gfat_src;
   logic [GL_HALF_W-1:0] gnf_src;
   logic [DATA_W-1:0]    gevt;
   always_comb begin
      gfat_src = gl_fat_evt_in;
      gnf_src  = gl_nf_evt_in;
      gfat_src[11:8] = gl_fat_evt_in[11:8] | ecc_to_chan(mem_ecc_fat_in);
      gnf_src[11:8]  = gl_nf_evt_in[11:8] | ecc_to_chan(mem_ecc_nf_in);
      gfat_src[PORT_NUM] = gl_fat_evt_in[PORT_NUM] | (|fat_unm);
      gnf_src[PORT_NUM]  = gl_nf_evt_in[PORT_NUM] | (|(nfc_unm & NFC_UNCORR_MASK));
      gevt = {gfat_src, gnf_src} & GFIRST_VALID;
   end

   // a half takes all simultaneous errors while empty; otherwise they go next
   logic [DATA_W-1:0] gfirst_reg;
   logic [DATA_W-1:0] gnext_reg;
   logic [DATA_W-1:0] gfirst_next;
   logic [DATA_W-1:0] to_first;
   logic [DATA_W-1:0] to_next;
   logic [DATA_W-1:0] gnext_set;
   logic              fat_empty;
   logic              nf_empty;
   always_comb begin
      fat_empty = (gfirst_reg[31:16] == '0);
      nf_empty  = (gfirst_reg[15:0] == '0);
      to_first  = gevt & {{GL_HALF_W{fat_empty}}, {GL_HALF_W{nf_empty}}};
      to_next   = gevt & ~to_first;
      gnext_set = to_next;
      gnext_set[GL_MEM_FAT_BIT] = |to_next[27:24];
      gnext_set[GL_MEM_NF_BIT]  = |to_next[11:8];
      gnext_set = gnext_set & GNEXT_VALID;
      gfirst_next = w1c_upd(gfirst_reg, to_first,
                            wr_gfirst ? wdata_in : '0) & GFIRST_VALID;
   end

   // global logs reset on power_good only, so they survive rst_in
   always_ff @(posedge ref_clk_in or negedge power_good_in) begin
      if (!power_good_in) begin
         gfirst_reg <= STICKY_RST;
         gnext_reg  <= STICKY_RST;
      end else if (ce_in) begin
         gfirst_reg <= gfirst_next;
         gnext_reg  <= w1c_upd(gnext_reg, gnext_set, wr_gnext ? wdata_in : '0);
      end
   end

   // detail-log enables follow the global first register alone
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fat_log_en_out <= 1'b0;
         nf_log_en_out  <= 1'b0;
      end else if (ce_in) begin
         fat_log_en_out <= (gfirst_next[31:16] == '0);
         nf_log_en_out  <= (gfirst_next[15:0] == '0);
      end
   end

   // unit errors forwarded to the central logic, split by port cluster
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         unit_cl23_out <= 1'b0;
         unit_cl47_out <= 1'b0;
      end else if (ce_in) begin
         unit_cl23_out <= vpp_unm && (PORT_NUM <= 3);
         unit_cl47_out <= vpp_unm && (PORT_NUM >= 4);
      end
   end

   // read mux; unmapped and reserved bits read zero
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      unique case (addr_in)
         OFS_GLOBAL_FIRST:   rd_mux = gfirst_reg;
         OFS_GLOBAL_NEXT:    rd_mux = gnext_reg;
         OFS_PORT_FIRST_FAT: rd_mux = 32'(fat_if.first);
         OFS_PORT_NEXT_FAT:  rd_mux = 32'(fat_if.next);
         OFS_PORT_FIRST_NFC: rd_mux = 32'(nfc_if.first);
         OFS_PORT_NEXT_NFC:  rd_mux = 32'(nfc_if.next);
         OFS_UNIT_FIRST:     rd_mux = 32'(unit_if.first);
         OFS_UNIT_NEXT:      rd_mux = 32'(unit_if.next);
         OFS_STOP_SCREAM:    rd_mux = 32'(stop_scream_flag_reg);
         default:            rd_mux = '0;
      endcase
   end

   // read data valid the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= RDATA_RST;
      end else if (ce_in) begin
         rdata_out <= rd_in ? rd_mux : '0;
      end
   end

   // checks
   sequence s_fat_err_empty;
      ce_in && fat_empty && (gevt[31:16] != '0);
   endsequence
   sequence s_fat_err_full;
      ce_in && !fat_empty && (gevt[31:16] != '0) && !wr_gnext;
   endsequence

   a_gfirst_takes_all: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      s_fat_err_empty |=> ((gfirst_reg[31:16] & $past(gevt[31:16])) == $past(gevt[31:16])))
      else $error("simultaneous fatal errors not all in first");
   a_gnext_later: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      s_fat_err_full |=> (gnext_reg[31:28] & $past(gevt[31:28])) == $past(gevt[31:28]))
      else $error("later fatal error missing from next");
   a_gfirst_frozen: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && !fat_empty && !wr_gfirst |=> gfirst_reg[31:16] == $past(gfirst_reg[31:16]))
      else $error("first fatal half changed after first error");
   a_gnext_mem_bit: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && !fat_empty && mem_ecc_fat_in[1] && !wr_gnext
      |=> gnext_reg[24] && gnext_reg[27:25] == 3'h0)
      else $error("memory fatal not folded to next bit 24");
   a_ecc_branch_map: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && fat_empty && mem_ecc_fat_in == 2'h2 && gl_fat_evt_in[11:8] == 4'h0
      |=> gfirst_reg[26] && !gfirst_reg[27] && !gfirst_reg[25])
      else $error("ecc branch 1 not logged on channel 2");
   // a quiet cycle under warm reset must leave the global logs as they were
   a_gl_sticky_reset: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      rst_in && ce_in && !wr_gfirst && !wr_gnext && (gevt == '0)
      |=> gfirst_reg == $past(gfirst_reg) && gnext_reg == $past(gnext_reg))
      else $error("global logs disturbed by reset");
   a_sld_rw: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && nfc_if.wr_next && !nfc_unm[NFC_SLD_BIT]
      |=> nfc_if.next[NFC_SLD_BIT] == $past(wdata_in[NFC_SLD_BIT]))
      else $error("surprise link down bit not read-write");
   a_mask_blocks: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && port_fat_mask_in[0] && !fat_if.first[0] |=> !fat_if.first[0])
      else $error("masked error was logged");
   a_unit_first: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && vpp_unm && !unit_if.first[0] && !unit_if.wr_next
      |=> unit_if.first[0] && (unit_if.next[0] == $past(unit_if.next[0])))
      else $error("unit first bit not set by first error");
   a_unit_next: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && vpp_unm && unit_if.first[0] |=> unit_if.next[0])
      else $error("unit next bit not set by later error");
   a_stop_scream_flag_set: assert property (@(posedge ref_clk_in) disable iff (!power_good_in)
      ce_in && stop_scream_flag_evt_in |=> stop_scream_flag_reg)
      else $error("stop-and-scream flag not set");
   a_unit_forward: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ce_in && vpp_unm |=> (unit_cl23_out ^ unit_cl47_out) && (unit_cl23_out == (PORT_NUM <= 3)))
      else $error("unit error not forwarded to one cluster");
   // the enable flops hold their reset value at the release edge, so start one edge later
   a_log_en_tracks: assert property (@(posedge ref_clk_in) disable iff (rst_in || !power_good_in)
      (ce_in && !rst_in) ##1 ce_in |-> fat_log_en_out == fat_empty)
      else $error("log enable does not follow global first");
   a_rdata_timing: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ce_in && !rd_in |=> rdata_out == '0)
      else $error("read data outside its cycle");

endmodule : fnel_top

// ---- sim/fnel_err_src.sv ----
// fnel_err_src: model of the error sources that feed the logger, one port plus the central units.
// assumes: one clock; each error is a one-cycle pulse launched just after a rising edge.
`timescale 1ns/1ps
module fnel_err_src
   import fnel_pkg::*;
(
   input  wire logic                  clk_in,
   output logic      [PORT_FAT_W-1:0] fat_out,
   output logic      [PORT_NFC_W-1:0] nfc_out,
   output logic      [GL_HALF_W-1:0]  glf_out,
   output logic      [GL_HALF_W-1:0]  gln_out,
   output logic      [1:0]            eccf_out,
   output logic      [1:0]            eccn_out,
   output logic                       vpp_out,
   output logic                       ss_out
);
   initial {fat_out, nfc_out, glf_out, gln_out, eccf_out, eccn_out, vpp_out, ss_out} = '0;
   // one pulse per call; returning on the clearing edge keeps two calls off the same edge
   task automatic pulse(input int sel, input logic [31:0] v);
      @(posedge clk_in);
      case (sel)
         0: fat_out <= v[PORT_FAT_W-1:0];
         1: nfc_out <= v[PORT_NFC_W-1:0];
         2: glf_out <= v[GL_HALF_W-1:0];
         3: gln_out <= v[GL_HALF_W-1:0];
         4: eccf_out <= v[1:0];
         5: eccn_out <= v[1:0];
         6: vpp_out <= v[0];
         default: ss_out <= v[0];
      endcase
      @(posedge clk_in);
      {fat_out, nfc_out, glf_out, gln_out, eccf_out, eccn_out, vpp_out, ss_out} <= '0;
   endtask : pulse
endmodule : fnel_err_src

// ---- sim/tb_first_next_error_logger.sv ----
// tb_first_next_error_logger: table of error cases, then reset, clear, mask and bus cases.
// assumes: PORT_NUM 2, so port errors land on global bits 18 and 2 and forward to cluster 2-3.
`timescale 1ns/1ps
module tb_first_next_error_logger
   import fnel_pkg::*;
;
   typedef struct {int sel; logic [31:0] v; bit twice; logic [11:0] a; logic [31:0] e;} fnel_row_t;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, power_good_in = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [12:0] fat_e, fat_m = '0;
   logic [17:0] nfc_e, nfc_m = '0;
   logic [15:0] glf, gln;
   logic [1:0]  eccf, eccn;
   logic        vpp_e, vpp_m = 1'b0, ss_e, fat_en, nf_en, cl23, cl47;
   int          mismatches = 0, checks_done = 0;
   fnel_row_t rows [15] = '{
      '{0, 32'h0000_0200, 1, 12'h15C, 32'h0000_0200},
      '{0, 32'h0000_0003, 1, 12'h15C, 32'h0000_0003},
      '{0, 32'h0000_0010, 0, 12'h040, 32'h0004_0000},
      '{0, 32'h0000_0010, 1, 12'h044, 32'h0004_0000},
      '{1, 32'h0001_0800, 1, 12'h160, 32'h0001_0800},
      '{1, 32'h0000_0401, 1, 12'h160, 32'h0000_0401},
      '{1, 32'h0000_0401, 0, 12'h160, 32'h0000_0000},
      '{2, 32'h0000_FFFF, 0, 12'h040, 32'hFFFD_0000},
      '{3, 32'h0000_FFFF, 0, 12'h040, 32'h0000_FFFD},
      '{2, 32'h0000_FFFF, 1, 12'h044, 32'hF1FD_0000},
      '{4, 32'h0000_0002, 1, 12'h040, 32'h0400_0000},
      '{5, 32'h0000_0001, 0, 12'h040, 32'h0000_0100},
      '{6, 32'h0000_0001, 0, 12'h168, 32'h0000_0001},
      '{6, 32'h0000_0001, 1, 12'h16C, 32'h0000_0001},
      '{7, 32'h0000_0001, 0, 12'h170, 32'h0000_0001}
   };
   always #12.5 ref_clk_in = ~ref_clk_in;
   fnel_err_src SRC (.clk_in(ref_clk_in), .fat_out(fat_e), .nfc_out(nfc_e), .glf_out(glf), .gln_out(gln),
      .eccf_out(eccf), .eccn_out(eccn), .vpp_out(vpp_e), .ss_out(ss_e));
   fnel_top #(.PORT_NUM(2)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce),
      .power_good_in(power_good_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .port_fat_evt_in(fat_e), .port_fat_mask_in(fat_m), .port_nfc_evt_in(nfc_e),
      .port_nfc_mask_in(nfc_m), .vpp_evt_in(vpp_e), .vpp_mask_in(vpp_m), .stop_scream_flag_evt_in(ss_e),
      .gl_fat_evt_in(glf), .gl_nf_evt_in(gln), .mem_ecc_fat_in(eccf), .mem_ecc_nf_in(eccn),
      .fat_log_en_out(fat_en), .nf_log_en_out(nf_en), .unit_cl23_out(cl23), .unit_cl47_out(cl47));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask : chk
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe, so look just after that edge
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk_in);
      {rd, addr} <= {1'b1, a};
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_chk
   // power good low is the only thing that empties the logs between cases
   task automatic pg_clear();
      @(posedge ref_clk_in);
      power_good_in <= 1'b0;
      @(posedge ref_clk_in);
      power_good_in <= 1'b1;
   endtask : pg_clear
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5000) @(posedge ref_clk_in);
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      {rst_in, power_good_in} <= 2'b01;
      foreach (rows[i]) begin
         pg_clear();
         SRC.pulse(rows[i].sel, rows[i].v);
         if (rows[i].twice) SRC.pulse(rows[i].sel, rows[i].v);
         rd_chk(rows[i].a, rows[i].e);
      end
      $display("table test done");
      pg_clear();
      SRC.pulse(2, 32'h0000_8000);
      SRC.pulse(2, 32'h0000_8000);
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk(12'h040, 32'h8000_0000);
      rd_chk(12'h044, 32'h8000_0000);
      chk({31'h0, fat_en}, 32'h0);
      wr_reg(12'h040, 32'h0);
      rd_chk(12'h040, 32'h8000_0000);
      wr_reg(12'h040, 32'h8000_0000);
      rd_chk(12'h040, 32'h0);
      chk({31'h0, fat_en}, 32'h1);
      $display("warm reset and clear test done");
      SRC.pulse(0, 32'h20);
      SRC.pulse(0, 32'h20);
      fork
         SRC.pulse(0, 32'h20);
         wr_reg(12'h15C, 32'h20);
      join
      rd_chk(12'h15C, 32'h20);
      $display("set beats clear test done");
      pg_clear();
      @(posedge ref_clk_in);
      {fat_m, vpp_m} <= '1;
      SRC.pulse(0, 32'h1FFF);
      SRC.pulse(6, 32'h1);
      rd_chk(12'h154, 32'h0);
      rd_chk(12'h168, 32'h0);
      chk({30'h0, fat_en, nf_en}, 32'h3);
      @(posedge ref_clk_in);
      {fat_m, vpp_m} <= '0;
      $display("mask test done");
      SRC.pulse(6, 32'h1);
      #1 chk({30'h0, cl23, cl47}, 32'h2);
      $display("unit forward test done");
      // surprise link down in the next log is plain read-write, so a second one keeps it
      wr_reg(12'h160, 32'h0002_0000);
      rd_chk(12'h160, 32'h0002_0000);
      wr_reg(12'h160, 32'h0002_0000);
      rd_chk(12'h160, 32'h0002_0000);
      wr_reg(12'h160, 32'h0);
      rd_chk(12'h160, 32'h0);
      wr_reg(12'h100, 32'hFFFF_FFFF);
      rd_chk(12'h100, 32'h0);
      $display("read-write and unmapped test done");
      // a frozen cycle loses its error and its write alike
      @(posedge ref_clk_in);
      ce <= 1'b0;
      SRC.pulse(7, 32'h1);
      wr_reg(12'h160, 32'h0002_0000);
      @(posedge ref_clk_in);
      ce <= 1'b1;
      rd_chk(12'h170, 32'h0);
      rd_chk(12'h160, 32'h0);
      $display("clock enable test done");
      // a poisoning error in the clearing cycle keeps the flag set
      SRC.pulse(7, 32'h1);
      fork
         SRC.pulse(7, 32'h1);
         wr_reg(12'h170, 32'h1);
      join
      rd_chk(12'h170, 32'h1);
      $display("flag set beats clear test done");
      wrap_up();
   end
endmodule : tb_first_next_error_logger
